// file: design/ddc_defines.svh
// Constants for the dual converter serial command port.
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
`define DDC_WORD_BITS          16
`define DDC_CODE_BITS          8
`define DDC_POWER_DOWN_POS     12
`define DDC_LOAD_ENABLE_POS    11
`define DDC_DEFERRED_POS       10
`define DDC_CHAN_B_POS         9
`define DDC_CHAN_A_POS         8
`define DDC_CODE_RESET         8'h00
`define DDC_WORD_RESET         16'h0000
`define DDC_SCLK_MAX_HZ        10000000
`endif

// file: design/ddc_pkg.sv
// Types shared by the dual converter serial command port.
package ddc_pkg;
   typedef struct packed {
      logic       power_down_bit;
      logic       converter_load_enable_bit;
      logic       deferred_update_select_bit;
      logic       channel_b_select_bit;
      logic       channel_a_select_bit;
      logic [7:0] data;
   } ddc_cmd_t;

   typedef struct packed {
      logic [7:0] input_code;
      logic [7:0] conv_code;
      logic       shutdown;
   } ddc_chan_t;

   typedef enum logic [1:0] {
      DDC_IDLE,
      DDC_SHIFT,
      DDC_WAIT_LOAD
   } ddc_state_t;
endpackage

// file: design/ddc_sync.sv
// Two-flop synchroniser for one link pin.
module ddc_sync
   import ddc_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic rst_val,
   input  wire logic pin,
   output logic      sync_q
);
   logic meta_q;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         // Reset to the pin's idle level so that release shows no edge.
         meta_q <= rst_val;
         sync_q <= rst_val;
      end
      else
      begin
         meta_q <= pin;
         sync_q <= meta_q;
      end
   end
endmodule

// file: design/ddc_port.sv
// Serial command port and channel registers of the dual converter.
// Overview of operation
// R1: Reset clears all input and converter registers to zero.
// R2: Bits shift in only while chip select is held low.
// R3: Each serial clock rising edge shifts data-in into a 16-bit register.
// R4: The command runs on the chip select rising edge, not before.
// R5: Deferred update copies input to converter on load strobe fall.
// R6: Each channel keeps separate input and converter registers.
// R7: Each channel holds its own shutdown state.
// R8: Eight-bit codes per channel; output follows the converter register.
// R9: Host keeps the serial clock at or below 10 MHz.
// R10: Word is MSB first: three spare, control, address, eight data bits.
// R11: Control bits act independently; power-down bit shuts addressed channels.
// R12: Load enable updates converters now, or on strobe when deferred.
// R13: Channel select bits load the data byte into input registers.
// R14: Chip select rising after other counts acts on the last 16 bits.
`include "ddc_defines.svh"
module ddc_port
   import ddc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic       din,
   input  wire logic       load_strobe_n,
   output logic [7:0]      channel_a_output,
   output logic [7:0]      channel_b_output,
   output logic            channel_a_shutdown,
   output logic            channel_b_shutdown,
   output logic            load_pending
);
   // ------------------------------------------------------------
   // Latency and limits
   // ------------------------------------------------------------
   // Every link pin is sampled by clk, so each phase of the serial
   // clock and each data bit must stand for at least three clk
   // periods to be seen once and only once.
   // A command reaches the code and shutdown outputs four clk edges after chip select
   // is first sampled high: two in the synchroniser, one into the
   // channel registers and one into the output flops.
   // A load strobe fall takes the same path and the same time.
   // Frames shorter than sixteen bits are not refused; older bits
   // left at the top of the shift register are acted on as they stand.

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic cs_s;
   logic sclk_s;
   logic din_s;
   logic ld_s;
   logic cs_prev_q;
   logic sclk_prev_q;
   logic ld_prev_q;

   // Each synchroniser resets to the idle level of its pin, so the first
   // cycles after reset show no false chip select or strobe edge.
   ddc_sync u_cs (.clk(clk), .reset(reset), .rst_val(1'b1),
                  .pin(cs_n), .sync_q(cs_s));
   ddc_sync u_sck (.clk(clk), .reset(reset), .rst_val(1'b0),
                   .pin(sclk), .sync_q(sclk_s));
   ddc_sync u_din (.clk(clk), .reset(reset), .rst_val(1'b0),
                   .pin(din), .sync_q(din_s));
   ddc_sync u_ld (.clk(clk), .reset(reset), .rst_val(1'b1),
                  .pin(load_strobe_n), .sync_q(ld_s));

   // ------------------------------------------------------------
   // Edge detection
   // ------------------------------------------------------------
   // Data and serial clock pass equal synchronisers, so the bit read at
   // a detected rising edge is the one that stood on the pin at that edge.
   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire cs_rise   = cs_s & ~cs_prev_q;
   wire ld_fall   = ~ld_s & ld_prev_q;
   wire shift_en  = sclk_rise & ~cs_s;             // see R2 see R3

   // ------------------------------------------------------------
   // Shift register and command decode
   // ------------------------------------------------------------
   logic [15:0] shift_q;
   logic [15:0] shift_d;
   ddc_cmd_t    cmd;
   ddc_state_t  state_q;
   ddc_state_t  state_d;

   // Oldest bits fall off the top, so only the last 16 are kept.
   assign shift_d = shift_en ? {shift_q[14:0], din_s}
                             : shift_q;            // see R3 see R10 see R14
   assign cmd = ddc_cmd_t'(shift_q[12:0]);         // see R10

   wire exec      = cs_rise;                       // see R4
   wire upd_now   = exec & cmd.converter_load_enable_bit
                  & ~cmd.deferred_update_select_bit;       // see R12
   wire upd_later = exec & cmd.converter_load_enable_bit
                  & cmd.deferred_update_select_bit;        // see R12
   // A strobe fall counts only while armed, so stray strobes are ignored.
   wire upd_strobe = (state_q == DDC_WAIT_LOAD) & ld_fall; // see R5

   // The machine remembers whether a frame is open and whether a deferred update is armed; the
   // shift register itself needs no state to collect bits.
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         DDC_IDLE:
            if (~cs_s)
               state_d = DDC_SHIFT;
         DDC_SHIFT:
            if (upd_later)
               state_d = DDC_WAIT_LOAD;
            else if (exec)
               state_d = DDC_IDLE;
         DDC_WAIT_LOAD:
            // A new frame cancels a strobe still waiting.
            if (upd_strobe)
               state_d = DDC_IDLE;
            else if (~cs_s)
               state_d = DDC_SHIFT;
         default:
            state_d = DDC_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Channel registers
   // ------------------------------------------------------------
   // A channel that is not addressed keeps its input code and shutdown.
   ddc_chan_t chan_q [2];
   wire       upd_conv = upd_now | upd_strobe;     // see R12

   // Picks the select bit of one channel from a command word; the
   // input load and the shutdown write both use it.
   function automatic logic chan_hit(input ddc_cmd_t c,
                                     input logic     is_b);
      chan_hit = is_b ? c.channel_b_select_bit : c.channel_a_select_bit;
   endfunction

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_chan
         ddc_chan_t nx;
         wire load_in = exec & chan_hit(cmd, g == 1); // see R13
         always_comb
         begin
            nx = chan_q[g];
            if (load_in)
               nx.input_code = cmd.data;           // see R6 see R8
            if (load_in)
               nx.shutdown = cmd.power_down_bit;   // see R7 see R11
            // Converter copies the newly loaded code when both coincide.
            if (upd_conv)
               nx.conv_code = load_in & upd_now ? cmd.data
                                                : chan_q[g].input_code;
         end
         always_ff @(posedge clk)
         begin
            if (reset)
               chan_q[g] <= '0;                    // see R1
            else
               chan_q[g] <= nx;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Sequential state and outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         shift_q     <= `DDC_WORD_RESET;           // see R1
         state_q     <= DDC_IDLE;
         // Idle levels, matching the synchronisers, so no edge at release.
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
         ld_prev_q   <= 1'b1;
      end
      else
      begin
         shift_q     <= shift_d;
         state_q     <= state_d;
         cs_prev_q   <= cs_s;
         sclk_prev_q <= sclk_s;
         ld_prev_q   <= ld_s;
      end
   end

   // Converter codes drive the outputs one cycle behind the channel
   // registers; the extra cycle keeps every output straight from a flop.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         channel_a_output <= `DDC_CODE_RESET;
         channel_b_output <= `DDC_CODE_RESET;
      end
      else
      begin
         channel_a_output <= chan_q[0].conv_code;  // see R8
         channel_b_output <= chan_q[1].conv_code;  // see R8
      end
   end

   // Pending follows the next state so it rises with the arming edge.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         channel_a_shutdown <= 1'b0;
         channel_b_shutdown <= 1'b0;
         load_pending       <= 1'b0;
      end
      else
      begin
         channel_a_shutdown <= chan_q[0].shutdown;  // see R7
         channel_b_shutdown <= chan_q[1].shutdown;  // see R7
         load_pending       <= (state_d == DDC_WAIT_LOAD);
      end
   end
endmodule

// file: sim/ddc_host.sv
// Host model driving the three-wire link and the load strobe.
module ddc_host
(
   input  wire logic clk,
   output logic      cs_n = 1'b1,
   output logic      sclk = 1'b0,
   output logic      din = 1'b0,
   output logic      load_strobe_n = 1'b1
);
   timeunit 1ns;
   timeprecision 100ps;
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Four system clocks a phase give a 5 MHz link with wide margins.
   task automatic send(input logic [17:0] w, input int n, input logic sel);
      cs_n = !sel;
      hold(4);
      for (int i = n - 1; i >= 0; i--)
      begin
         din = w[i];
         hold(4);
         sclk = 1'b1;
         hold(4);
         sclk = 1'b0;
      end
      // The line is not held after the last bit, so flip it.
      din = !din;
      hold(4);
      cs_n = 1'b1;
      hold(14);
   endtask
   task automatic strobe();
      load_strobe_n = 1'b0;
      hold(10);
      load_strobe_n = 1'b1;
      hold(10);
   endtask
endmodule

// file: sim/ddc_port_chk.sv
// Concurrent checks on the ports of the serial command port.
module ddc_port_chk
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       cs_n,
   input wire logic       load_strobe_n,
   input wire logic [7:0] channel_a_output,
   input wire logic [7:0] channel_b_output,
   input wire logic       channel_a_shutdown,
   input wire logic       channel_b_shutdown,
   input wire logic       load_pending
);
   // Cycles since chip select went high and since the strobe went low.
   logic [3:0] hi_q;
   logic [3:0] lo_q;
   wire logic [18:0] outs = {channel_a_output, channel_b_output,
      channel_a_shutdown, channel_b_shutdown, load_pending};
   wire logic cs_win = hi_q >= 4'h2 && hi_q <= 4'h9;
   wire logic st_win = lo_q >= 4'h2 && lo_q <= 4'h9;
   wire logic idle = cs_n && load_strobe_n;
   always_ff @(posedge clk)
   begin
      hi_q <= (reset || !cs_n) ? 4'h0 : hi_q + {3'h0, hi_q != 4'hF};
      lo_q <= (reset || load_strobe_n) ? 4'h0 : lo_q + {3'h0, lo_q != 4'hF};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_rst; $fell(reset) |-> !(|outs); endproperty
   a_rst: assert property (p_rst) else $error("not cleared");
   property p_a; $changed(channel_a_output) |-> cs_win || st_win; endproperty
   a_a: assert property (p_a) else $error("code a moved");
   property p_b; $changed(channel_b_output) |-> cs_win || st_win; endproperty
   a_b: assert property (p_b) else $error("code b moved");
   property p_sd; $changed(outs[2:1]) |-> cs_win; endproperty
   a_sd: assert property (p_sd) else $error("shutdown moved");
   property p_rise; $rose(load_pending) |-> cs_win; endproperty
   a_rise: assert property (p_rise) else $error("early arm");
   property p_fall; $fell(load_pending) |-> st_win || hi_q == 4'h0; endproperty
   a_fall: assert property (p_fall) else $error("arm lost");
   property p_hold; load_pending && idle |=> load_pending; endproperty
   a_hold: assert property (p_hold) else $error("arm dropped");
   property p_ign; $fell(load_strobe_n) && !load_pending && hi_q > 4'h8
      |=> $stable(outs) [*8]; endproperty
   a_ign: assert property (p_ign) else $error("stray load");
endmodule
bind ddc_port ddc_port_chk i_ddc_port_chk (.clk(clk), .reset(reset),
   .cs_n(cs_n), .load_strobe_n(load_strobe_n),
   .channel_a_output(channel_a_output),
   .channel_b_output(channel_b_output),
   .channel_a_shutdown(channel_a_shutdown),
   .channel_b_shutdown(channel_b_shutdown),
   .load_pending(load_pending));

// file: sim/testbench.sv
// Self-checking bench for the serial command port.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk;
   logic       reset;
   logic       cs_n, sclk, din, load_strobe_n;
   logic [7:0] channel_a_output, channel_b_output;
   logic       channel_a_shutdown, channel_b_shutdown, load_pending;
   int         n_fail = 0;
   int         n_checks = 0;
   wire logic [18:0] seen = {channel_a_output, channel_b_output,
      channel_a_shutdown, channel_b_shutdown, load_pending};
   ddc_port i_ddc_port (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
      .din(din), .load_strobe_n(load_strobe_n),
      .channel_a_output(channel_a_output),
      .channel_b_output(channel_b_output),
      .channel_a_shutdown(channel_a_shutdown),
      .channel_b_shutdown(channel_b_shutdown),
      .load_pending(load_pending));
   ddc_host i_ddc_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din),
      .load_strobe_n(load_strobe_n));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = !clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [18:0] e);
      n_checks++;
      if (seen !== e)
      begin
         n_fail++;
         $display("CHECK FAILED outputs expected %h seen %h", e, seen);
      end
   endtask
   task automatic go(input logic [15:0] w, input logic [18:0] e);
      i_ddc_host.send({2'b00, w}, 16, 1'b1);
      chk(e);
   endtask
   initial
   begin
      reset = 1'b1;
      i_ddc_host.hold(4);
      reset = 1'b0;
      i_ddc_host.hold(6);
      chk({8'h00,8'h00,3'b000});
      go(16'h0155, {8'h00,8'h00,3'b000});
      go(16'h0800, {8'h55,8'h00,3'b000});
      go(16'h09A5, {8'hA5,8'h00,3'b000});
      go(16'h0E3C, {8'hA5,8'h00,3'b001});
      i_ddc_host.strobe();
      chk({8'hA5,8'h3C,3'b000});
      go(16'h1100, {8'hA5,8'h3C,3'b100});
      go(16'h1200, {8'hA5,8'h3C,3'b110});
      go(16'h0100, {8'hA5,8'h3C,3'b010});
      i_ddc_host.send(18'h3_0B77, 18, 1'b1);
      chk({8'h77,8'h77,3'b000});
      i_ddc_host.send(18'h0_0B00, 16, 1'b0);
      chk({8'h77,8'h77,3'b000});
      go(16'h0C11, {8'h77,8'h77,3'b001});
      go(16'h0166, {8'h77,8'h77,3'b000});
      i_ddc_host.strobe();
      chk({8'h77,8'h77,3'b000});
      go(16'h0800, {8'h66,8'h77,3'b000});
      reset = 1'b1;
      i_ddc_host.hold(4);
      reset = 1'b0;
      i_ddc_host.hold(6);
      chk({8'h00,8'h00,3'b000});
      go(16'h0800, {8'h00,8'h00,3'b000});
      results();
   end
   initial
   begin
      repeat (10000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule
